// ==== core/ctstr_pkg.sv ====
package ctstr_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int unsigned CTSTR_NUM_TRIG = 32;
   localparam int unsigned CTSTR_NUM_CHAN = 4;
   localparam int unsigned CTSTR_NUM_GPO = 8;
   localparam int unsigned CTSTR_NUM_TAG = 4;
   localparam int unsigned CTSTR_AW = 12;
   localparam int unsigned CTSTR_NUM_EVT = 5;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] TRIGGER_OUTPUT_LEVEL_VIEW_OFS = 12'h134;
   localparam logic [11:0] CHANNEL_INPUT_LEVEL_VIEW_OFS = 12'h138;
   localparam logic [11:0] CHANNEL_OUTPUT_LEVEL_VIEW_OFS = 12'h13c;
   localparam logic [11:0] CHANNEL_PROPAGATION_GATE_OFS = 12'h140;
   localparam logic [11:0] EXTERNAL_OUTPUT_CONTROL_OFS = 12'h144;
   localparam logic [11:0] EVENT_STATUS_OFS = 12'h148;
   localparam logic [11:0] EVENT_MASK_OFS = 12'h14c;
   localparam logic [11:0] TEST_CHANNEL_PULSE_OFS = 12'hee4;
   localparam logic [11:0] TEST_TRIGGER_FORCE_OFS = 12'hee8;
   localparam logic [11:0] TEST_CHANNEL_LATCH_OFS = 12'hef4;
   localparam logic [11:0] TEST_TRIGGER_LATCH_OFS = 12'hef8;
   localparam logic [11:0] INTEGRATION_MODE_CONTROL_OFS = 12'hf00;
   localparam logic [11:0] OWNERSHIP_TAG_SET_OFS = 12'hfa0;
   localparam logic [11:0] OWNERSHIP_TAG_CLEAR_OFS = 12'hfa4;
   localparam logic [11:0] AFFINITY_LOW_WORD_OFS = 12'hfa8;
   localparam logic [11:0] AFFINITY_HIGH_WORD_OFS = 12'hfac;

   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int unsigned INTEGRATION_MODE_BIT = 0;
   localparam int unsigned EVT_TRIG_BIT = 4;
   localparam logic [3:0] GATE_RESET = 4'hf;
   localparam logic [3:0] TAG_IMPLEMENTED = 4'hf;
   localparam logic [7:0] GPO_RESET = 8'h00;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } ctstr_bus_req_t;

   typedef struct packed {
      logic [CTSTR_NUM_TRIG-1:0] trig;
      logic [CTSTR_NUM_CHAN-1:0] chan;
   } ctstr_evt_t;

   typedef struct packed {
      ctstr_evt_t sync1;
      ctstr_evt_t sync2;
      ctstr_evt_t sync3;
      ctstr_evt_t level;
      logic [3:0] gate;
      logic [7:0] gpo;
      logic [3:0] pulse;
      logic [31:0] force_lvl;
      logic [3:0] chan_latch;
      logic [31:0] trig_latch;
      logic int_mode;
      logic [3:0] tag;
      logic [4:0] evt_status;
      logic [4:0] evt_mask;
      logic [31:0] trig_out;
      logic [3:0] chan_out;
      logic [3:0] chan_in_gated;
      logic irq;
      logic [31:0] rdata;
   } ctstr_state_t;
endpackage : ctstr_pkg

// ==== core/ctstr_regs.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - Read-only view of all 32 trigger output levels, 1 high, 0 low.
// - Read-only view of the 4 channel input levels.
// - Read-only view of the 4 channel output levels.
// - Status views sample live levels; short pulses usually read as 0.
// - Gate bit per channel lets events leave; all four reset to 1.
// - 8-bit register drives general-purpose output bus directly; resets to zero.
// - In integration mode, writing 1 pulses that channel output for one cycle; self-clearing field.
// - 32-bit force register drives trigger outputs in integration mode; reads return stored value.
// - Sticky latch per channel input sets, in integration mode only, on any pulse that passes the input filter.
// - Reading a latch register clears the bits it returned.
// - Sticky latch per trigger input, read through its own register.
// - Integration mode enable bit 0, resets to 0.
// - Tag set location sets bits on write 1; reads all ones.
// - Tag clear location clears bits on write 1; reads current tag.
// - Tag bits affect nothing else in the unit.
// - Affinity low word returns tie-off bits 31:0.
// - Affinity high word returns tie-off bits 63:32.
// - Gate masks channel inputs too; exactly four channels.
module ctstr_regs
   import ctstr_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic [11:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   input wire logic [31:0] trig_in,
   input wire logic [3:0] chan_in,
   input wire logic [31:0] map_trig_out_in,
   input wire logic [3:0] map_chan_out_in,
   input wire logic [63:0] affinity_in,
   output logic [31:0] trig_out,
   output logic [3:0] chan_out,
   output logic [3:0] chan_in_gated_out,
   output logic [7:0] gpo_out,
   output logic irq_out
);

   ctstr_bus_req_t req;
   ctstr_evt_t rise;
   ctstr_state_t st_r;
   ctstr_state_t st_nxt;

   assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

   // ----------------------------------------
   // Input edges
   // ----------------------------------------
   // Filtered level only moves when stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < CTSTR_NUM_TRIG; gi++)
      begin : g_trig
         assign rise.trig[gi] = (st_r.sync2.trig[gi] == st_r.sync3.trig[gi])
            && st_r.sync3.trig[gi] && !st_r.level.trig[gi];
      end
      for (gi = 0; gi < CTSTR_NUM_CHAN; gi++)
      begin : g_chan
         assign rise.chan[gi] = (st_r.sync2.chan[gi] == st_r.sync3.chan[gi])
            && st_r.sync3.chan[gi] && !st_r.level.chan[gi];
      end
   endgenerate

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      logic [4:0] evt;
      logic [3:0] chan_hit;
      logic [31:0] trig_hit;
      evt = '0;
      chan_hit = '0;
      trig_hit = '0;
      st_nxt = st_r;

      st_nxt.sync1 = '{trig: trig_in, chan: chan_in};
      st_nxt.sync2 = st_r.sync1;
      st_nxt.sync3 = st_r.sync2;
      for (int i = 0; i < CTSTR_NUM_TRIG; i++)
      begin
         if (st_r.sync2.trig[i] == st_r.sync3.trig[i])
         begin
            st_nxt.level.trig[i] = st_r.sync3.trig[i];
         end
      end
      for (int i = 0; i < CTSTR_NUM_CHAN; i++)
      begin
         if (st_r.sync2.chan[i] == st_r.sync3.chan[i])
         begin
            st_nxt.level.chan[i] = st_r.sync3.chan[i];
         end
      end

      // Self-clearing: a written pulse lives for one cycle only
      st_nxt.pulse = '0;

      // Latches are cleared by a read; a pulse in the same cycle still sets
      if (req.rd && req.addr == TEST_CHANNEL_LATCH_OFS)
      begin
         chan_hit = st_r.chan_latch;
      end
      if (req.rd && req.addr == TEST_TRIGGER_LATCH_OFS)
      begin
         trig_hit = st_r.trig_latch;
      end
      st_nxt.chan_latch = (st_r.chan_latch & ~chan_hit)
         | (st_r.int_mode ? st_r.level.chan : 4'h0);
      st_nxt.trig_latch = (st_r.trig_latch & ~trig_hit)
         | (st_r.int_mode ? st_r.level.trig : 32'h0);

      evt[3:0] = rise.chan;
      evt[EVT_TRIG_BIT] = |rise.trig;

      if (req.wr)
      begin
         case (req.addr)
            CHANNEL_PROPAGATION_GATE_OFS: st_nxt.gate = req.wdata[3:0];
            EXTERNAL_OUTPUT_CONTROL_OFS: st_nxt.gpo = req.wdata[7:0];
            EVENT_STATUS_OFS: st_nxt.evt_status = st_r.evt_status & ~req.wdata[4:0];
            EVENT_MASK_OFS: st_nxt.evt_mask = req.wdata[4:0];
            TEST_CHANNEL_PULSE_OFS: st_nxt.pulse = req.wdata[3:0];
            TEST_TRIGGER_FORCE_OFS: st_nxt.force_lvl = req.wdata;
            INTEGRATION_MODE_CONTROL_OFS:
               st_nxt.int_mode = req.wdata[INTEGRATION_MODE_BIT];
            OWNERSHIP_TAG_SET_OFS: st_nxt.tag = st_r.tag | req.wdata[3:0];
            OWNERSHIP_TAG_CLEAR_OFS: st_nxt.tag = st_r.tag & ~req.wdata[3:0];
            default: st_nxt.tag = st_nxt.tag;
         endcase
      end
      // Set wins over a write-one-to-clear in the same cycle
      st_nxt.evt_status = st_nxt.evt_status | evt;

      // ----------------------------------------
      // Pin drive
      // ----------------------------------------
      // Tag is deliberately absent from every output path
      if (st_r.int_mode)
      begin
         st_nxt.trig_out = st_r.force_lvl;
         st_nxt.chan_out = st_r.pulse;
      end
      else
      begin
         st_nxt.trig_out = map_trig_out_in;
         st_nxt.chan_out = map_chan_out_in & st_r.gate;
      end
      // Input gating: a closed channel never reaches the mapping logic
      st_nxt.chan_in_gated = st_r.level.chan & st_r.gate;
      st_nxt.irq = |(st_r.evt_status & st_r.evt_mask);

      // ----------------------------------------
      // Read data, one cycle after the strobe
      // ----------------------------------------
      st_nxt.rdata = '0;
      if (req.rd)
      begin
         case (req.addr)
            TRIGGER_OUTPUT_LEVEL_VIEW_OFS: st_nxt.rdata = st_r.trig_out;
            CHANNEL_INPUT_LEVEL_VIEW_OFS:
               st_nxt.rdata = {28'h0000000, st_r.level.chan};
            CHANNEL_OUTPUT_LEVEL_VIEW_OFS:
               st_nxt.rdata = {28'h0000000, st_r.chan_out};
            CHANNEL_PROPAGATION_GATE_OFS: st_nxt.rdata = {28'h0000000, st_r.gate};
            EXTERNAL_OUTPUT_CONTROL_OFS: st_nxt.rdata = {24'h000000, st_r.gpo};
            EVENT_STATUS_OFS: st_nxt.rdata = {27'h0000000, st_r.evt_status};
            EVENT_MASK_OFS: st_nxt.rdata = {27'h0000000, st_r.evt_mask};
            TEST_CHANNEL_PULSE_OFS: st_nxt.rdata = 32'h00000000;
            TEST_TRIGGER_FORCE_OFS: st_nxt.rdata = st_r.force_lvl;
            TEST_CHANNEL_LATCH_OFS:
               st_nxt.rdata = {28'h0000000, st_r.chan_latch};
            TEST_TRIGGER_LATCH_OFS: st_nxt.rdata = st_r.trig_latch;
            INTEGRATION_MODE_CONTROL_OFS: st_nxt.rdata = {31'h00000000, st_r.int_mode};
            OWNERSHIP_TAG_SET_OFS: st_nxt.rdata = {28'h0000000, TAG_IMPLEMENTED};
            OWNERSHIP_TAG_CLEAR_OFS: st_nxt.rdata = {28'h0000000, st_r.tag};
            AFFINITY_LOW_WORD_OFS: st_nxt.rdata = affinity_in[31:0];
            AFFINITY_HIGH_WORD_OFS: st_nxt.rdata = affinity_in[63:32];
            default: st_nxt.rdata = 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge core_clk_in)
   begin
      if (reset_in)
      begin
         st_r <= '0;
         st_r.gate <= GATE_RESET;
         st_r.gpo <= GPO_RESET;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata_out = st_r.rdata;
   assign trig_out = st_r.trig_out;
   assign chan_out = st_r.chan_out;
   assign chan_in_gated_out = st_r.chan_in_gated;
   assign gpo_out = st_r.gpo;
   assign irq_out = st_r.irq;

endmodule : ctstr_regs

// ==== verification/ctstr_regs_checker.sv ====
`timescale 1ns/10ps
module ctstr_regs_checker
   import ctstr_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic [11:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic [63:0] affinity_in,
   input wire logic [31:0] trig_out,
   input wire logic [7:0] gpo_out
);
   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (reset_in);
   // Own copy of the mode bit, so forcing is judged only when it may act
   logic intm_r;
   always_ff @(posedge core_clk_in)
      if (reset_in)
         intm_r <= 1'b0;
      else if (reg_wr_in && reg_addr_in == INTEGRATION_MODE_CONTROL_OFS)
         intm_r <= reg_wdata_in[0];
   a_gpo_write: assert property (
      reg_wr_in && reg_addr_in == EXTERNAL_OUTPUT_CONTROL_OFS
      |=> gpo_out == $past(reg_wdata_in[7:0])) else $error("gpo bus missed write");
   a_gpo_hold: assert property (
      !(reg_wr_in && reg_addr_in == EXTERNAL_OUTPUT_CONTROL_OFS)
      |=> $stable(gpo_out)) else $error("gpo bus moved without write");
   a_aff_low: assert property (
      reg_rd_in && reg_addr_in == AFFINITY_LOW_WORD_OFS
      |=> reg_rdata_out == $past(affinity_in[31:0])) else $error("bad affinity low");
   a_aff_high: assert property (
      reg_rd_in && reg_addr_in == AFFINITY_HIGH_WORD_OFS
      |=> reg_rdata_out == $past(affinity_in[63:32])) else $error("bad affinity high");
   a_tagset_read: assert property (
      reg_rd_in && reg_addr_in == OWNERSHIP_TAG_SET_OFS
      |=> reg_rdata_out == 32'hf) else $error("tag set read not all ones");
   a_pulse_read: assert property (
      reg_rd_in && reg_addr_in == TEST_CHANNEL_PULSE_OFS
      |=> reg_rdata_out == 32'h0) else $error("pulse field not self clearing");
   a_trig_view: assert property (
      reg_rd_in && reg_addr_in == TRIGGER_OUTPUT_LEVEL_VIEW_OFS
      |=> reg_rdata_out == $past(trig_out)) else $error("trigger view mismatch");
   a_trig_force: assert property (
      intm_r && reg_wr_in && reg_addr_in == TEST_TRIGGER_FORCE_OFS
      |=> ##1 trig_out == $past(reg_wdata_in, 2)) else $error("forced trigger lost");
endmodule : ctstr_regs_checker
bind ctstr_regs ctstr_regs_checker chk (.*);

// ==== verification/ctstr_peer.sv ====
`timescale 1ns/10ps
module ctstr_peer
   import ctstr_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic [31:0] trig_req_in,
   input wire logic [3:0] chan_req_in,
   input wire logic [31:0] map_req_in,
   output logic [31:0] trig_pin_out,
   output logic [3:0] chan_pin_out,
   output logic [31:0] map_trig_out,
   output logic [3:0] map_chan_out
);
   // Neighbours are clocked logic: levels move just after an edge
   always_ff @(posedge core_clk_in)
   begin
      trig_pin_out <= trig_req_in;
      chan_pin_out <= chan_req_in;
      map_trig_out <= ~map_req_in;
      map_chan_out <= 4'hf;
   end
endmodule : ctstr_peer

// ==== verification/tb.sv ====
`timescale 1ns/10ps
module tb;
   import ctstr_pkg::*;
   // ----------------------------------------
   // Harness
   // ----------------------------------------
   localparam logic [63:0] AFF = 64'h0123_4567_89ab_cdef; // Arbitrary tie-off
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [11:0] addr = 12'h0;
   logic [31:0] wd = 32'h0, treq = 32'h0, mreq = 32'h0, rdat, tin, mtr, tout;
   logic [3:0] creq = 4'h0, cin, mch, cout, cg;
   logic [7:0] gpo;
   logic irq;
   int fail_count = 0, checked = 0;
   initial forever #20 clk = ~clk;
   ctstr_peer peer (.core_clk_in(clk), .trig_req_in(treq), .chan_req_in(creq),
      .map_req_in(mreq), .trig_pin_out(tin), .chan_pin_out(cin), .map_trig_out(mtr),
      .map_chan_out(mch));
   ctstr_regs uut (.core_clk_in(clk), .reset_in(rst), .reg_addr_in(addr),
      .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
      .trig_in(tin), .chan_in(cin), .map_trig_out_in(mtr), .map_chan_out_in(mch),
      .affinity_in(AFF), .trig_out(tout), .chan_out(cout), .chan_in_gated_out(cg),
      .gpo_out(gpo), .irq_out(irq));
   task ck(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         fail_count++;
      end
   endtask : ck
   task reg_w(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_w
   task reg_r(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 ck($sformatf("reg %h", a), e, rdat);
   endtask : reg_r
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task wrap_up;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      repeat (5000) @(posedge clk);
      $display("ERROR timeout expected end seen hang");
      fail_count++;
      wrap_up;
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      reg_r(CHANNEL_PROPAGATION_GATE_OFS, 32'hf);
      reg_r(EXTERNAL_OUTPUT_CONTROL_OFS, 32'h0);
      reg_r(INTEGRATION_MODE_CONTROL_OFS, 32'h0);
      reg_r(OWNERSHIP_TAG_SET_OFS, 32'hf);
      reg_r(OWNERSHIP_TAG_CLEAR_OFS, 32'h0);
      reg_r(AFFINITY_LOW_WORD_OFS, AFF[31:0]);
      reg_r(AFFINITY_HIGH_WORD_OFS, AFF[63:32]);
      reg_r(12'h200, 32'h0);
      $display("test reset done");
      reg_w(CHANNEL_PROPAGATION_GATE_OFS, 32'h5);
      reg_w(EXTERNAL_OUTPUT_CONTROL_OFS, 32'ha5);
      reg_w(12'h200, 32'hffff_ffff);
      reg_w(TEST_TRIGGER_FORCE_OFS, 32'h1234_5678);
      creq <= 4'h9;
      mreq <= 32'h00ff_00ff;
      cyc(8);
      ck("gpo", 32'ha5, {24'h0, gpo});
      ck("chan_out", 32'h5, {28'h0, cout});
      ck("gated", 32'h1, {28'h0, cg});
      ck("trig_out", 32'hff00_ff00, tout);
      reg_r(EXTERNAL_OUTPUT_CONTROL_OFS, 32'ha5);
      reg_r(TRIGGER_OUTPUT_LEVEL_VIEW_OFS, 32'hff00_ff00);
      reg_r(CHANNEL_INPUT_LEVEL_VIEW_OFS, 32'h9);
      reg_r(CHANNEL_OUTPUT_LEVEL_VIEW_OFS, 32'h5);
      reg_r(TEST_CHANNEL_LATCH_OFS, 32'h0);
      $display("test normal done");
      reg_w(INTEGRATION_MODE_CONTROL_OFS, 32'h1);
      cyc(2);
      ck("trig_out", 32'h1234_5678, tout);
      reg_r(INTEGRATION_MODE_CONTROL_OFS, 32'h1);
      reg_r(TEST_TRIGGER_FORCE_OFS, 32'h1234_5678);
      reg_r(TRIGGER_OUTPUT_LEVEL_VIEW_OFS, 32'h1234_5678);
      // Force rewritten while the mode is on, so the checker's force path is exercised
      reg_w(TEST_TRIGGER_FORCE_OFS, 32'h8765_4321);
      cyc(2);
      ck("trig_out", 32'h8765_4321, tout);
      reg_r(TEST_CHANNEL_LATCH_OFS, 32'h9);
      @(posedge clk) creq <= 4'h0;
      treq <= 32'h8000_0001;
      cyc(3);
      @(posedge clk) treq <= 32'h0;
      cyc(8);
      reg_r(TEST_CHANNEL_LATCH_OFS, 32'h9);
      reg_r(TEST_CHANNEL_LATCH_OFS, 32'h0);
      reg_r(TEST_TRIGGER_LATCH_OFS, 32'h8000_0001);
      reg_r(TEST_TRIGGER_LATCH_OFS, 32'h0);
      reg_w(TEST_CHANNEL_PULSE_OFS, 32'h5);
      cyc(1);
      ck("pulse", 32'h5, {28'h0, cout});
      cyc(1);
      ck("pulse", 32'h0, {28'h0, cout});
      reg_r(TEST_CHANNEL_PULSE_OFS, 32'h0);
      // Leaving the mode hands the pins back to the mapping logic
      reg_w(INTEGRATION_MODE_CONTROL_OFS, 32'h0);
      cyc(2);
      ck("trig_out", 32'hff00_ff00, tout);
      ck("chan_out", 32'h5, {28'h0, cout});
      $display("test integration done");
      reg_w(OWNERSHIP_TAG_SET_OFS, 32'h3);
      reg_r(OWNERSHIP_TAG_CLEAR_OFS, 32'h3);
      reg_w(OWNERSHIP_TAG_CLEAR_OFS, 32'h1);
      reg_r(OWNERSHIP_TAG_CLEAR_OFS, 32'h2);
      reg_r(OWNERSHIP_TAG_SET_OFS, 32'hf);
      reg_r(CHANNEL_PROPAGATION_GATE_OFS, 32'h5);
      $display("test tags done");
      // Rising edges seen so far: channels 0 and 3, one trigger event
      reg_r(EVENT_STATUS_OFS, 32'h19);
      ck("irq", 32'h0, {31'h0, irq});
      reg_w(EVENT_MASK_OFS, 32'h10);
      cyc(2);
      ck("irq", 32'h1, {31'h0, irq});
      reg_w(EVENT_STATUS_OFS, 32'h10);
      cyc(2);
      ck("irq", 32'h0, {31'h0, irq});
      reg_r(EVENT_STATUS_OFS, 32'h9);
      $display("test interrupt done");
      wrap_up;
   end
endmodule : tb
